// ==== logic/drive_comm_pkg.sv ====
`default_nettype none
package drive_comm_pkg;

  // ************************************************************
  // register word addresses
  // ************************************************************
  localparam logic [15:0] ADDR_REPLY_DELAY  = 16'h030E;
  localparam logic [15:0] ADDR_MONITOR_MODE = 16'h0310;
  localparam logic [15:0] ADDR_SYNC_TUNING  = 16'h0312;
  localparam logic [15:0] ADDR_FAULT_LATEST = 16'h0400;
  localparam logic [15:0] ADDR_FAULT_PREV1  = 16'h0402;
  localparam logic [15:0] ADDR_FAULT_PREV2  = 16'h0404;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [15:0] RST_REPLY_DELAY  = 16'h0000;
  localparam logic [15:0] RST_MONITOR_MODE = 16'h0000;
  localparam logic [15:0] RST_SYNC_TUNING  = 16'h57A1;
  localparam logic [31:0] RST_FAULT        = 32'h0000_0000;

  // ************************************************************
  // field layout
  // ************************************************************
  localparam int NIB_W         = 4;
  localparam int MON_MODE_LSB  = 0;
  localparam int MON_INT_LSB   = 4;
  localparam int SYNC_STEP_LSB = 0;
  localparam int SYNC_DEAD_LSB = 4;
  localparam int SYNC_TGT_LSB  = 8;
  localparam int SYNC_ERR_LSB  = 12;
  localparam int WORD_W        = 16;

  // ************************************************************
  // field limits
  // ************************************************************
  localparam logic [15:0] REPLY_DELAY_MAX = 16'h03E8;
  localparam logic [3:0]  MON_MODE_MAX    = 4'h3;
  localparam logic [3:0]  STEP_MIN        = 4'h1;
  localparam logic [3:0]  TGT_MAX         = 4'h9;
  localparam logic [3:0]  ERR_MIN         = 4'h1;
  localparam logic [3:0]  ERR_MAX         = 4'h9;
  localparam logic [15:0] TGT_BASE_US     = 16'h0190;
  localparam logic [15:0] TGT_STEP_US     = 16'h000A;
  localparam logic [15:0] ERR_UNIT_US     = 16'h000A;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int NS_PER_S      = 1_000_000_000;
  localparam int MS_UNIT_NS    = 1_000_000;
  localparam int MS_CYCLES     = MS_UNIT_NS / CLK_PERIOD_NS;
  localparam int HS4_RATE_HZ   = 8000;
  localparam int HS2_RATE_HZ   = 16000;
  localparam int HS4_CYCLES    = NS_PER_S / (HS4_RATE_HZ * CLK_PERIOD_NS);
  localparam int HS2_CYCLES    = NS_PER_S / (HS2_RATE_HZ * CLK_PERIOD_NS);

  // ************************************************************
  // channel counts and modes
  // ************************************************************
  localparam int CH_NUM     = 4;
  localparam int CH_HS2_NUM = 2;

  typedef enum logic [1:0] {
    MON_OFF = 2'h0,
    MON_LOW = 2'h1,
    MON_HS4 = 2'h2,
    MON_HS2 = 2'h3
  } mon_mode_t;

  typedef enum logic [1:0] {
    PUSH_IDLE = 2'b01,
    PUSH_BUSY = 2'b10
  } push_state_t;

  typedef enum logic [1:0] {
    REPLY_IDLE = 2'b01,
    REPLY_WAIT = 2'b10
  } reply_state_t;

endpackage
`default_nettype wire

// ==== logic/stream_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(
  parameter int W = 16
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport prod (output valid, output data, input ready);
  modport cons (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== logic/stream_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  stream_if.cons    in_s,
  stream_if.prod    out_s
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_s.ready  = (cnt_q != FULL_CNT);
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data  = mem[rd_q];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_s.data;
    end
  end

  // ************************************************************
  // pointers and fill level
  // ************************************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      case ({push, pop})
        2'b10:   cnt_q <= cnt_q + 1'b1;
        2'b01:   cnt_q <= cnt_q - 1'b1;
        default: cnt_q <= cnt_q;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== logic/drive_comm_monitor_sync_params.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - reply held back 0..1000 ms
// - mode 0..3, zero stops monitoring
// - mode 1: four channels, interval field
// - mode 2: four channels, 8000 per second
// - mode 3: two channels, 16000 per second
// - nonzero interval L: message every L ms
// - low-speed message: four 16-bit values
// - low speed only in mode 1, L nonzero
// - clock step limited to step field
// - no correction inside dead zone
// - target time 400 plus 10 times T
// - locked when deviation below window of 10us times error field
// - record: alarm low, bus code high
// - latest and older records kept apart
module drive_comm_monitor_sync_params #(
  parameter int MS_CYC      = drive_comm_pkg::MS_CYCLES,
  parameter int FIFO_DEPTH  = 16,
  parameter int FAULT_DEPTH = 3
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic      [31:0] reg_rdata_o,
  output logic             reg_ack_o,
  output logic             reg_err_o,
  input  wire logic        reply_req_i,
  output logic             reply_go_o,
  output logic             reply_busy_o,
  input  wire logic [63:0] ch_data_i,
  output logic      [15:0] mon_data_o,
  output logic             mon_valid_o,
  input  wire logic        mon_ready_i,
  input  wire logic        sync_meas_valid_i,
  input  wire logic [15:0] sync_meas_us_i,
  output logic             corr_valid_o,
  output logic signed [7:0] corr_step_us_o,
  output logic             sync_locked_o,
  input  wire logic        fault_i,
  input  wire logic [15:0] fault_alarm_i,
  input  wire logic [15:0] fault_can_i
);

  // ************************************************************
  // register file
  // ************************************************************
  logic [15:0]  reply_delay_q;
  logic [15:0]  monitor_mode_q;
  logic [15:0]  sync_tuning_q;
  logic [31:0]  fault_q [FAULT_DEPTH];
  logic [3:0]   wr_mode;
  logic [3:0]   wr_int;
  logic [3:0]   wr_step;
  logic [3:0]   wr_dead;
  logic [3:0]   wr_tgt;
  logic [3:0]   wr_err;
  logic         addr_hit;
  logic         addr_ro;
  logic [31:0]  rd_mux;

  always_comb begin
    wr_mode = reg_wdata_i[drive_comm_pkg::MON_MODE_LSB +: drive_comm_pkg::NIB_W];
    wr_int  = reg_wdata_i[drive_comm_pkg::MON_INT_LSB +: drive_comm_pkg::NIB_W];
    wr_step = reg_wdata_i[drive_comm_pkg::SYNC_STEP_LSB +: drive_comm_pkg::NIB_W];
    wr_dead = reg_wdata_i[drive_comm_pkg::SYNC_DEAD_LSB +: drive_comm_pkg::NIB_W];
    wr_tgt  = reg_wdata_i[drive_comm_pkg::SYNC_TGT_LSB +: drive_comm_pkg::NIB_W];
    wr_err  = reg_wdata_i[drive_comm_pkg::SYNC_ERR_LSB +: drive_comm_pkg::NIB_W];
    if (wr_step < drive_comm_pkg::STEP_MIN) begin
      wr_step = drive_comm_pkg::STEP_MIN;
    end
    if (wr_tgt > drive_comm_pkg::TGT_MAX) begin
      wr_tgt = drive_comm_pkg::TGT_MAX;
    end
    if (wr_err < drive_comm_pkg::ERR_MIN) begin
      wr_err = drive_comm_pkg::ERR_MIN;
    end else if (wr_err > drive_comm_pkg::ERR_MAX) begin
      wr_err = drive_comm_pkg::ERR_MAX;
    end
  end

  always_comb begin
    addr_hit = 1'b1;
    addr_ro  = 1'b0;
    rd_mux   = 32'h0000_0000;
    case (reg_addr_i)
      drive_comm_pkg::ADDR_REPLY_DELAY:  rd_mux = {16'h0000, reply_delay_q};
      drive_comm_pkg::ADDR_MONITOR_MODE: rd_mux = {16'h0000, monitor_mode_q};
      drive_comm_pkg::ADDR_SYNC_TUNING:  rd_mux = {16'h0000, sync_tuning_q};
      drive_comm_pkg::ADDR_FAULT_LATEST: begin
        rd_mux  = fault_q[0];
        addr_ro = 1'b1;
      end
      drive_comm_pkg::ADDR_FAULT_PREV1: begin
        rd_mux  = fault_q[1];
        addr_ro = 1'b1;
      end
      drive_comm_pkg::ADDR_FAULT_PREV2: begin
        rd_mux  = fault_q[2];
        addr_ro = 1'b1;
      end
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reply_delay_q  <= drive_comm_pkg::RST_REPLY_DELAY;
      monitor_mode_q <= drive_comm_pkg::RST_MONITOR_MODE;
      sync_tuning_q  <= drive_comm_pkg::RST_SYNC_TUNING;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        drive_comm_pkg::ADDR_REPLY_DELAY: begin
          if (reg_wdata_i[15:0] > drive_comm_pkg::REPLY_DELAY_MAX) begin
            reply_delay_q <= drive_comm_pkg::REPLY_DELAY_MAX;
          end else begin
            reply_delay_q <= reg_wdata_i[15:0];
          end
        end
        drive_comm_pkg::ADDR_MONITOR_MODE: begin
          if (wr_mode <= drive_comm_pkg::MON_MODE_MAX) begin
            monitor_mode_q <= {8'h00, wr_int, wr_mode};
          end
        end
        drive_comm_pkg::ADDR_SYNC_TUNING: begin
          sync_tuning_q <= {wr_err, wr_tgt, wr_dead, wr_step};
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
      reg_ack_o   <= 1'b0;
      reg_err_o   <= 1'b0;
    end else begin
      reg_ack_o   <= reg_wr_i | reg_rd_i;
      reg_err_o   <= (reg_wr_i | reg_rd_i) & (~addr_hit | (reg_wr_i & addr_ro));
      reg_rdata_o <= (reg_rd_i & addr_hit) ? rd_mux : 32'h0000_0000;
    end
  end

  // ************************************************************
  // fault history
  // ************************************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < FAULT_DEPTH; i++) begin
        fault_q[i] <= drive_comm_pkg::RST_FAULT;
      end
    end else if (fault_i) begin
      for (int i = FAULT_DEPTH - 1; i > 0; i--) begin
        fault_q[i] <= fault_q[i-1];
      end
      fault_q[0] <= {fault_can_i, fault_alarm_i};
    end
  end

  // ************************************************************
  // reply delay
  // ************************************************************
  drive_comm_pkg::reply_state_t reply_st_q;
  logic [31:0]  reply_sub_q;
  logic [15:0]  reply_ms_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reply_st_q  <= drive_comm_pkg::REPLY_IDLE;
      reply_sub_q <= 32'h0000_0000;
      reply_ms_q  <= 16'h0000;
      reply_go_o  <= 1'b0;
      reply_busy_o <= 1'b0;
    end else begin
      reply_go_o <= 1'b0;
      case (reply_st_q)
        drive_comm_pkg::REPLY_IDLE: begin
          if (reply_req_i) begin
            if (reply_delay_q == 16'h0000) begin
              reply_go_o <= 1'b1;
            end else begin
              reply_st_q  <= drive_comm_pkg::REPLY_WAIT;
              reply_busy_o <= 1'b1;
              reply_sub_q <= 32'h0000_0000;
              reply_ms_q  <= reply_delay_q;
            end
          end
        end
        drive_comm_pkg::REPLY_WAIT: begin
          if (reply_sub_q == 32'(MS_CYC - 1)) begin
            reply_sub_q <= 32'h0000_0000;
            if (reply_ms_q == 16'h0001) begin
              reply_go_o <= 1'b1;
              reply_busy_o <= 1'b0;
              reply_st_q <= drive_comm_pkg::REPLY_IDLE;
            end
            reply_ms_q <= reply_ms_q - 16'h0001;
          end else begin
            reply_sub_q <= reply_sub_q + 32'h0000_0001;
          end
        end
        default: reply_st_q <= drive_comm_pkg::REPLY_IDLE;
      endcase
    end
  end

  // ************************************************************
  // monitor sample timing
  // ************************************************************
  drive_comm_pkg::mon_mode_t mode;
  logic [3:0]  interval;
  logic        mon_on;
  logic [31:0] period;
  logic [31:0] mon_sub_q;
  logic [3:0]  mon_ms_q;
  logic        tick;

  assign mode     = drive_comm_pkg::mon_mode_t'(monitor_mode_q[drive_comm_pkg::MON_MODE_LSB +: 2]);
  assign interval = monitor_mode_q[drive_comm_pkg::MON_INT_LSB +: drive_comm_pkg::NIB_W];

  always_comb begin
    case (mode)
      drive_comm_pkg::MON_LOW: begin
        mon_on = (interval != 4'h0);
        period = 32'(MS_CYC);
      end
      drive_comm_pkg::MON_HS4: begin
        mon_on = 1'b1;
        period = 32'(drive_comm_pkg::HS4_CYCLES);
      end
      drive_comm_pkg::MON_HS2: begin
        mon_on = 1'b1;
        period = 32'(drive_comm_pkg::HS2_CYCLES);
      end
      default: begin
        mon_on = 1'b0;
        period = 32'(MS_CYC);
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mon_sub_q <= 32'h0000_0000;
      mon_ms_q  <= 4'h0;
      tick      <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!mon_on || (reg_wr_i && reg_addr_i == drive_comm_pkg::ADDR_MONITOR_MODE)) begin
        mon_sub_q <= 32'h0000_0000;
        mon_ms_q  <= 4'h0;
      end else if (mon_sub_q >= period - 32'h0000_0001) begin
        mon_sub_q <= 32'h0000_0000;
        if (mode != drive_comm_pkg::MON_LOW) begin
          tick <= 1'b1;
        end else if (mon_ms_q >= interval - 4'h1) begin
          mon_ms_q <= 4'h0;
          tick     <= 1'b1;
        end else begin
          mon_ms_q <= mon_ms_q + 4'h1;
        end
      end else begin
        mon_sub_q <= mon_sub_q + 32'h0000_0001;
      end
    end
  end

  // ************************************************************
  // sample set into fifo
  // ************************************************************
  stream_if #(.W(drive_comm_pkg::WORD_W)) push_s ();
  stream_if #(.W(drive_comm_pkg::WORD_W)) pop_s ();

  drive_comm_pkg::push_state_t push_st_q;
  logic [63:0] snap_q;
  logic [1:0]  ch_idx_q;
  logic [1:0]  ch_last_q;

  assign push_s.valid = (push_st_q == drive_comm_pkg::PUSH_BUSY);
  assign push_s.data  = snap_q[ch_idx_q*drive_comm_pkg::WORD_W +: drive_comm_pkg::WORD_W];

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      push_st_q <= drive_comm_pkg::PUSH_IDLE;
      snap_q    <= 64'h0000_0000_0000_0000;
      ch_idx_q  <= 2'h0;
      ch_last_q <= 2'h0;
    end else begin
      case (push_st_q)
        drive_comm_pkg::PUSH_IDLE: begin
          if (tick && mon_on) begin
            snap_q    <= ch_data_i;
            ch_idx_q  <= 2'h0;
            ch_last_q <= (mode == drive_comm_pkg::MON_HS2) ?
                         2'(drive_comm_pkg::CH_HS2_NUM - 1) :
                         2'(drive_comm_pkg::CH_NUM - 1);
            push_st_q <= drive_comm_pkg::PUSH_BUSY;
          end
        end
        drive_comm_pkg::PUSH_BUSY: begin
          if (!mon_on) begin
            push_st_q <= drive_comm_pkg::PUSH_IDLE;
          end else if (push_s.ready) begin
            ch_idx_q <= ch_idx_q + 2'h1;
            if (ch_idx_q == ch_last_q) begin
              push_st_q <= drive_comm_pkg::PUSH_IDLE;
            end
          end
        end
        default: push_st_q <= drive_comm_pkg::PUSH_IDLE;
      endcase
    end
  end

  stream_fifo #(
    .W     (drive_comm_pkg::WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .in_s      (push_s),
    .out_s     (pop_s)
  );

  assign pop_s.ready = ~mon_valid_o | mon_ready_i;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mon_valid_o <= 1'b0;
      mon_data_o  <= 16'h0000;
    end else if (pop_s.ready) begin
      mon_valid_o <= pop_s.valid;
      if (pop_s.valid) begin
        mon_data_o <= pop_s.data;
      end
    end
  end

  // ************************************************************
  // synchronisation tuner
  // ************************************************************
  logic [3:0]         f_step;
  logic [3:0]         f_dead;
  logic [3:0]         f_tgt;
  logic [3:0]         f_err;
  logic [15:0]        target_us;
  logic [15:0]        window_us;
  logic signed [16:0] dev;
  logic [16:0]        dev_abs;
  logic [7:0]         step_mag;

  always_comb begin
    f_step    = sync_tuning_q[drive_comm_pkg::SYNC_STEP_LSB +: drive_comm_pkg::NIB_W];
    f_dead    = sync_tuning_q[drive_comm_pkg::SYNC_DEAD_LSB +: drive_comm_pkg::NIB_W];
    f_tgt     = sync_tuning_q[drive_comm_pkg::SYNC_TGT_LSB +: drive_comm_pkg::NIB_W];
    f_err     = sync_tuning_q[drive_comm_pkg::SYNC_ERR_LSB +: drive_comm_pkg::NIB_W];
    target_us = 16'(drive_comm_pkg::TGT_BASE_US + drive_comm_pkg::TGT_STEP_US * f_tgt);
    window_us = 16'(drive_comm_pkg::ERR_UNIT_US * f_err);
    dev       = $signed({1'b0, sync_meas_us_i}) - $signed({1'b0, target_us});
    dev_abs   = dev[16] ? 17'(-dev) : 17'(dev);
    step_mag  = (dev_abs > 17'(f_step)) ? {4'h0, f_step} : dev_abs[7:0];
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      corr_valid_o   <= 1'b0;
      corr_step_us_o <= 8'sh00;
      sync_locked_o  <= 1'b0;
    end else begin
      corr_valid_o <= 1'b0;
      if (sync_meas_valid_i) begin
        sync_locked_o <= (dev_abs < 17'(window_us));
        if (dev_abs > 17'(f_dead)) begin
          corr_valid_o   <= 1'b1;
          corr_step_us_o <= dev[16] ? -$signed(step_mag) : $signed(step_mag);
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== testbench/drive_comm_props_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module drive_comm_props (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        reg_ack_o,
  input wire logic        reg_err_o,
  input wire logic        reply_go_o,
  input wire logic        reply_busy_o,
  input wire logic [15:0] mon_data_o,
  input wire logic        mon_valid_o,
  input wire logic        mon_ready_i,
  input wire logic        sync_meas_valid_i,
  input wire logic        corr_valid_o,
  input wire logic [7:0]  corr_step_us_o,
  input wire logic        sync_locked_o,
  input wire logic        fault_i,
  input wire logic [15:0] fault_alarm_i,
  input wire logic [15:0] fault_can_i
);
  // ****************************************
  // port checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_ack;
    (reg_wr_i || reg_rd_i) |=> reg_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack after strobe");

  property p_ro_err;
    reg_wr_i && (reg_addr_i inside {16'h0400, 16'h0402, 16'h0404}) |=> reg_ack_o && reg_err_o;
  endproperty
  a_ro_err: assert property (p_ro_err) else $error("record write not refused");

  property p_go;
    $fell(reply_busy_o) |-> reply_go_o;
  endproperty
  a_go: assert property (p_go) else $error("delay ended without reply");

  property p_corr;
    corr_valid_o |-> $past(sync_meas_valid_i);
  endproperty
  a_corr: assert property (p_corr) else $error("correction without measurement");

  property p_step;
    corr_valid_o |-> corr_step_us_o != 0 && $signed(corr_step_us_o) <= 15
      && $signed(corr_step_us_o) >= -15;
  endproperty
  a_step: assert property (p_step) else $error("correction step out of range");

  property p_hold;
    mon_valid_o && !mon_ready_i |=> mon_valid_o && $stable(mon_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("monitor word dropped");

  property p_fault;
    fault_i ##1 (reg_rd_i && reg_addr_i == 16'h0400)
      |=> reg_rdata_o == {$past(fault_can_i, 2), $past(fault_alarm_i, 2)};
  endproperty
  a_fault: assert property (p_fault) else $error("latest record wrong");

  property p_lock;
    $changed(sync_locked_o) |-> $past(sync_meas_valid_i);
  endproperty
  a_lock: assert property (p_lock) else $error("lock moved without measurement");

  c_reply: cover property (reply_go_o && $past(reply_busy_o));
  c_stall: cover property (mon_valid_o && !mon_ready_i);
  c_neg:   cover property (corr_valid_o && $signed(corr_step_us_o) < 0);
endmodule
`default_nettype wire

// ==== testbench/monitor_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
module monitor_sink (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        valid_i,
  input  wire logic [15:0] data_i,
  input  wire logic [1:0]  stall_i,
  output logic             ready_o
);
  // ****************************************
  // host side: 0 prompt, 1 every other cycle, 2 halted
  // ****************************************
  logic [15:0] words[$];
  int          stamps[$];
  int          cyc;

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ready_o <= 1'b0;
      cyc     <= 0;
    end else begin
      cyc <= cyc + 1;
      if (valid_i && ready_o) begin
        words.push_back(data_i);
        stamps.push_back(cyc);
      end
      ready_o <= (stall_i == 2'h0) || (stall_i == 2'h1 && !ready_o);
    end
  end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************
  // stimulus and judging
  // ****************************************
  localparam int MS = 4;
  logic        clk_i             = 1'b0;
  logic        sys_rst_i         = 1'b1;
  logic [15:0] reg_addr_i        = 16'h0000;
  logic        reg_wr_i          = 1'b0;
  logic        reg_rd_i          = 1'b0;
  logic [31:0] reg_wdata_i       = 32'h0000_0000;
  logic        reply_req_i       = 1'b0;
  logic [63:0] ch_data_i         = 64'hD004_C003_B002_A001;
  logic        sync_meas_valid_i = 1'b0;
  logic [15:0] sync_meas_us_i    = 16'h0000;
  logic        fault_i           = 1'b0;
  logic [15:0] fault_alarm_i     = 16'h0000;
  logic [15:0] fault_can_i       = 16'h0000;
  logic [1:0]  stall             = 2'h0;
  logic [31:0] reg_rdata_o;
  logic        reg_ack_o;
  logic        reg_err_o;
  logic        reply_go_o;
  logic        reply_busy_o;
  logic [15:0] mon_data_o;
  logic        mon_valid_o;
  logic        mon_ready_i;
  logic        corr_valid_o;
  logic [7:0]  corr_step_us_o;
  logic        sync_locked_o;
  logic [31:0] rd;
  logic        er;
  int          err_total = 0;
  int          tests_run = 0;

  always #25 clk_i = ~clk_i;

  drive_comm_monitor_sync_params #(.MS_CYC(MS)) dut (
    .clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .reg_ack_o, .reg_err_o, .reply_req_i, .reply_go_o,
    .reply_busy_o, .ch_data_i, .mon_data_o, .mon_valid_o, .mon_ready_i,
    .sync_meas_valid_i, .sync_meas_us_i, .corr_valid_o, .corr_step_us_o,
    .sync_locked_o, .fault_i, .fault_alarm_i, .fault_can_i
  );

  monitor_sink sink (
    .clk_i, .sys_rst_i, .valid_i(mon_valid_o), .data_i(mon_data_o),
    .stall_i(stall), .ready_o(mon_ready_i)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    tick(1);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_wr_i    = w;
    reg_rd_i    = !w;
    tick(1);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    rd       = reg_rdata_o;
    er       = reg_err_o;
    check(reg_ack_o, 1);
  endtask

  task automatic t_reply(input logic [15:0] dly, input int exp_n);
    int n;
    bus(1, drive_comm_pkg::ADDR_REPLY_DELAY, {16'h0000, dly});
    tick(1);
    reply_req_i = 1'b1;
    tick(1);
    reply_req_i = 1'b0;
    n = 0;
    check(reply_busy_o, exp_n != 0);
    while (reply_go_o !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    check(n, exp_n);
  endtask

  task automatic t_mon(input logic [15:0] mw, input int sz, input int per, input logic [1:0] st);
    stall = st;
    sink.words.delete();
    sink.stamps.delete();
    bus(1, drive_comm_pkg::ADDR_MONITOR_MODE, {16'h0000, mw});
    tick(2 * per + 40);
    check(sink.words.size() >= 2 * sz, 1);
    for (int i = 0; i < 2 * sz; i++) begin
      check(sink.words[i], ch_data_i[16 * (i % sz) +: 16]);
    end
    if (st == 2'h0) begin
      check(sink.stamps[sz] - sink.stamps[0], per);
    end
    stall = 2'h0;
    bus(1, drive_comm_pkg::ADDR_MONITOR_MODE, 32'h0000_0000);
    tick(10);
    sink.words.delete();
    tick(per + 20);
    check(sink.words.size(), 0);
  endtask

  task automatic t_quiet(input logic [15:0] mw);
    sink.words.delete();
    bus(1, drive_comm_pkg::ADDR_MONITOR_MODE, {16'h0000, mw});
    tick(60);
    check(sink.words.size(), 0);
  endtask

  task automatic t_fifo;
    stall = 2'h2;
    sink.words.delete();
    bus(1, drive_comm_pkg::ADDR_MONITOR_MODE, 32'h0000_0011);
    tick(200);
    stall = 2'h0;
    tick(2);
    bus(1, drive_comm_pkg::ADDR_MONITOR_MODE, 32'h0000_0000);
    tick(60);
    check(sink.words.size() >= 16, 1);
    for (int i = 0; i < 16; i++) begin
      check(sink.words[i], ch_data_i[16 * (i % 4) +: 16]);
    end
  endtask

  task automatic sy(input logic [15:0] m, input logic cv, input logic [7:0] st, input logic lk);
    tick(1);
    sync_meas_valid_i = 1'b1;
    sync_meas_us_i    = m;
    tick(1);
    sync_meas_valid_i = 1'b0;
    check(corr_valid_o, cv);
    if (cv) begin
      check(corr_step_us_o, st);
    end
    check(sync_locked_o, lk);
  endtask

  task automatic fault(input logic [15:0] k);
    tick(1);
    fault_i       = 1'b1;
    fault_alarm_i = 16'hA000 + k;
    fault_can_i   = 16'hC000 + k;
    tick(1);
    fault_i = 1'b0;
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    tick(12);
    sys_rst_i = 1'b0;
    bus(0, drive_comm_pkg::ADDR_SYNC_TUNING, 32'h0);
    check(rd, 32'h0000_57A1);
    bus(0, drive_comm_pkg::ADDR_FAULT_PREV1, 32'h0);
    check(rd, 32'h0000_0000);
    bus(0, 16'h0311, 32'h0);
    check(er, 1);
    t_reply(16'h0000, 0);
    t_reply(16'h0003, 3 * MS);
    t_reply(16'h07D0, 1000 * MS);
    bus(0, drive_comm_pkg::ADDR_REPLY_DELAY, 32'h0);
    check(rd, 32'h0000_03E8);
    t_mon(16'h0031, 4, 3 * MS, 2'h0);
    t_mon(16'h0021, 4, 2 * MS, 2'h1);
    t_mon(16'h0002, 4, drive_comm_pkg::HS4_CYCLES, 2'h0);
    t_mon(16'h0003, 2, drive_comm_pkg::HS2_CYCLES, 2'h0);
    t_quiet(16'h0001);
    t_quiet(16'h0020);
    bus(1, drive_comm_pkg::ADDR_MONITOR_MODE, 32'h0000_0025);
    bus(0, drive_comm_pkg::ADDR_MONITOR_MODE, 32'h0);
    check(rd, 32'h0000_0020);
    t_fifo;
    bus(1, drive_comm_pkg::ADDR_SYNC_TUNING, 32'h0000_3532);
    sy(16'd450, 0, 8'h00, 1);
    sy(16'd453, 0, 8'h00, 1);
    sy(16'd454, 1, 8'h02, 1);
    sy(16'd479, 1, 8'h02, 1);
    sy(16'd480, 1, 8'h02, 0);
    sy(16'd445, 1, 8'hFE, 1);
    bus(1, drive_comm_pkg::ADDR_SYNC_TUNING, 32'h0000_0A00);
    bus(0, drive_comm_pkg::ADDR_SYNC_TUNING, 32'h0);
    check(rd, 32'h0000_1901);
    sy(16'd490, 0, 8'h00, 1);
    sy(16'd500, 1, 8'h01, 0);
    sy(16'd489, 1, 8'hFF, 1);
    fault(16'h0001);
    reg_addr_i = drive_comm_pkg::ADDR_FAULT_LATEST;
    reg_rd_i   = 1'b1;
    tick(1);
    reg_rd_i = 1'b0;
    check(reg_rdata_o, 32'hC001_A001);
    fault(16'h0002);
    fault(16'h0003);
    bus(1, drive_comm_pkg::ADDR_FAULT_PREV1, 32'h0);
    check(er, 1);
    for (int i = 0; i < 3; i++) begin
      bus(0, drive_comm_pkg::ADDR_FAULT_LATEST + 16'(2 * i), 32'h0);
      check(rd, {16'hC003 - 16'(i), 16'hA003 - 16'(i)});
    end
    final_report;
  end

  initial begin
    tick(100000);
    err_total++;
    final_report;
  end
endmodule

bind drive_comm_monitor_sync_params drive_comm_props u_props (.*);
`default_nettype wire
